/* File: rtl/tcs_pkg.sv */
// Constants and types of the torque command select block
package tcs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;
  localparam logic [15:0] ADDR_MODE       = 16'h0102;
  localparam logic [15:0] ADDR_SPRE1      = 16'h0112;
  localparam logic [15:0] ADDR_SPRE2      = 16'h0114;
  localparam logic [15:0] ADDR_SPRE3      = 16'h0116;
  localparam logic [15:0] ADDR_TPRE1      = 16'h0118;
  localparam logic [15:0] ADDR_TPRE2      = 16'h011a;
  localparam logic [15:0] ADDR_TPRE3      = 16'h011c;
  localparam logic [15:0] ADDR_FULL_SCALE = 16'h0152;
  localparam logic [15:0] ADDR_STATUS     = 16'h0200;
  localparam logic [15:0] ADDR_TORQUE_RD  = 16'h0202;
  localparam logic [15:0] ADDR_LIMIT_RD   = 16'h0204;

  // ****************************************************************
  // Reset values and ranges
  // ****************************************************************
  localparam logic [15:0] RST_FULL_SCALE  = 16'h0064;
  localparam logic [15:0] FULL_SCALE_MAX  = 16'h03e8;
  localparam logic [15:0] RST_PRESET      = 16'h0000;
  localparam logic signed [15:0] PRESET_MAX = 16'sh012c;
  localparam logic signed [15:0] TENTHS_PER_PCT = 16'sh000a;
  localparam logic signed [15:0] ANALOG_MAX_MV  = 16'sh2710;
  localparam int          MV_PER_V        = 1000;
  localparam int          FS_VOLTS        = 10;
  localparam int          SCALE_DIV       =
    MV_PER_V * FS_VOLTS / 10;

  // ****************************************************************
  // Mode codes
  // ****************************************************************
  localparam logic [7:0]  MODE_PT         = 8'h00;
  localparam logic [7:0]  MODE_PR         = 8'h01;
  localparam logic [7:0]  MODE_S          = 8'h02;
  localparam logic [7:0]  MODE_T          = 8'h03;
  localparam logic [7:0]  MODE_SZ         = 8'h04;
  localparam logic [7:0]  MODE_TZ         = 8'h05;
  localparam logic [7:0]  MODE_PT_S       = 8'h06;
  localparam logic [7:0]  MODE_PT_T       = 8'h07;
  localparam logic [7:0]  MODE_S_T        = 8'h0a;
  localparam logic [7:0]  RST_MODE        = 8'h03;

  // ****************************************************************
  // Pin vector layout and status fields
  // ****************************************************************
  localparam int          PIN_TSEL0       = 0;
  localparam int          PIN_TSEL1       = 1;
  localparam int          PIN_SSEL0       = 2;
  localparam int          PIN_SSEL1       = 3;
  localparam int          PIN_SP_SW       = 4;
  localparam int          PIN_TP_SW       = 5;
  localparam int          PIN_ST_SW       = 6;
  localparam int          PIN_N           = 7;
  localparam int          ST_CTL_LSB      = 0;
  localparam int          ST_ZERO_T       = 2;
  localparam int          ST_PULSE        = 3;
  localparam int          ST_LIMIT        = 4;
  localparam int          ST_TSEL_LSB     = 5;
  localparam int          LPF_FRAC        = 8;

  typedef enum logic [1:0] {
    CTL_PULSE_POS,
    CTL_PATH_POS,
    CTL_SPEED,
    CTL_TORQUE
  } tcs_ctl_e;

endpackage

/* File: rtl/tcs_top.sv */
// Torque command selection, dual mode switching and register port
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module tcs_top #(
  parameter int LPF_SHIFT = 4
) (
  input  wire logic                      sys_clk_in,
  input  wire logic                      arst_n_in,
  input  wire logic                      ce_in,
  input  wire logic [15:0]               addr_in,
  input  wire logic [15:0]               wr_data_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  input  wire logic                      torque_select_bit0_in,
  input  wire logic                      torque_select_bit1_in,
  input  wire logic                      speed_select_bit0_in,
  input  wire logic                      speed_select_bit1_in,
  input  wire logic                      speed_position_switch_in,
  input  wire logic                      torque_position_switch_in,
  input  wire logic                      speed_torque_switch_in,
  input  wire logic signed [15:0]        analog_ref_mv_in,
  input  wire logic                      analog_valid_in,
  output logic [15:0]                    rd_data_out,
  output logic signed [15:0]             torque_cmd_out,
  output logic signed [15:0]             torque_limit_out,
  output logic                           torque_limit_active_out,
  output logic signed [15:0]             speed_cmd_out,
  output logic [1:0]                     control_path_out,
  output logic                           pulse_position_enable_out,
  output logic [7:0]                     di_map_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [tcs_pkg::PIN_N-1:0] sync1;
    logic [tcs_pkg::PIN_N-1:0] sync2;
    logic [15:0]               full_scale;
    logic [7:0]                mode;
    logic signed [15:0]        tpre1;
    logic signed [15:0]        tpre2;
    logic signed [15:0]        tpre3;
    logic signed [15:0]        spre1;
    logic signed [15:0]        spre2;
    logic signed [15:0]        spre3;
    logic signed [23:0]        lpf;
    logic signed [15:0]        torque_cmd;
    logic signed [15:0]        torque_lim;
    logic                      lim_active;
    logic signed [15:0]        speed_cmd;
    tcs_pkg::tcs_ctl_e         ctl;
    logic                      zero_t;
    logic                      pulse_en;
    logic [7:0]                di_map;
    logic [15:0]               rdata;
  } tcs_state_s;

  localparam tcs_state_s RST_STATE = '{
    sync1:      '0,
    sync2:      '0,
    full_scale: tcs_pkg::RST_FULL_SCALE,
    mode:       tcs_pkg::RST_MODE,
    tpre1:      tcs_pkg::RST_PRESET,
    tpre2:      tcs_pkg::RST_PRESET,
    tpre3:      tcs_pkg::RST_PRESET,
    spre1:      tcs_pkg::RST_PRESET,
    spre2:      tcs_pkg::RST_PRESET,
    spre3:      tcs_pkg::RST_PRESET,
    lpf:        '0,
    torque_cmd: '0,
    torque_lim: '0,
    lim_active: 1'b0,
    speed_cmd:  '0,
    ctl:        tcs_pkg::CTL_TORQUE,
    zero_t:     1'b0,
    pulse_en:   1'b0,
    di_map:     tcs_pkg::RST_MODE,
    rdata:      '0
  };

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic signed [15:0] sat_pct(
    input logic signed [15:0] v
  );
    logic signed [15:0] r;
    r = v;
    if (v > tcs_pkg::PRESET_MAX) begin
      r = tcs_pkg::PRESET_MAX;
    end else if (v < -tcs_pkg::PRESET_MAX) begin
      r = -tcs_pkg::PRESET_MAX;
    end
    return r;
  endfunction

  function automatic logic mode_ok(input logic [7:0] m);
    return (m == tcs_pkg::MODE_PT) || (m == tcs_pkg::MODE_PR) ||
           (m == tcs_pkg::MODE_S) || (m == tcs_pkg::MODE_T) ||
           (m == tcs_pkg::MODE_SZ) || (m == tcs_pkg::MODE_TZ) ||
           (m == tcs_pkg::MODE_PT_S) || (m == tcs_pkg::MODE_PT_T) ||
           (m == tcs_pkg::MODE_S_T);
  endfunction

  tcs_state_s q;
  tcs_state_s n;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [1:0]         tsel;
    logic [1:0]         ssel;
    logic signed [15:0] vin;
    logic signed [31:0] prod;
    logic signed [31:0] scaled;
    logic signed [23:0] target;
    logic signed [15:0] analog_pct;
    logic signed [15:0] tsel_val;
    logic               zero_s;
    n          = q;
    tsel       = '0;
    ssel       = '0;
    vin        = '0;
    prod       = '0;
    scaled     = '0;
    target     = '0;
    analog_pct = '0;
    tsel_val   = '0;
    zero_s     = 1'b0;

    n.sync1 = {speed_torque_switch_in, torque_position_switch_in,
               speed_position_switch_in, speed_select_bit1_in,
               speed_select_bit0_in, torque_select_bit1_in,
               torque_select_bit0_in};
    n.sync2 = q.sync1;

    // Register writes
    if (wr_in) begin
      case (addr_in)
        tcs_pkg::ADDR_FULL_SCALE: begin
          n.full_scale = (wr_data_in > tcs_pkg::FULL_SCALE_MAX) ?
            tcs_pkg::FULL_SCALE_MAX : wr_data_in;
        end
        tcs_pkg::ADDR_MODE: begin
          if (mode_ok(wr_data_in[7:0]) && (wr_data_in[15:8] == 8'h00))
          begin
            n.mode   = wr_data_in[7:0];
            n.di_map = wr_data_in[7:0];
          end
        end
        tcs_pkg::ADDR_TPRE1: n.tpre1 = sat_pct(wr_data_in);
        tcs_pkg::ADDR_TPRE2: n.tpre2 = sat_pct(wr_data_in);
        tcs_pkg::ADDR_TPRE3: n.tpre3 = sat_pct(wr_data_in);
        tcs_pkg::ADDR_SPRE1: n.spre1 = wr_data_in;
        tcs_pkg::ADDR_SPRE2: n.spre2 = wr_data_in;
        tcs_pkg::ADDR_SPRE3: n.spre3 = wr_data_in;
        default: ;
      endcase
    end

    // Mode decode
    n.zero_t = 1'b0;
    zero_s   = 1'b0;
    case (q.mode)
      tcs_pkg::MODE_PT: n.ctl = tcs_pkg::CTL_PULSE_POS;
      tcs_pkg::MODE_PR: n.ctl = tcs_pkg::CTL_PATH_POS;
      tcs_pkg::MODE_S:  n.ctl = tcs_pkg::CTL_SPEED;
      tcs_pkg::MODE_SZ: begin
        n.ctl  = tcs_pkg::CTL_SPEED;
        zero_s = 1'b1;
      end
      tcs_pkg::MODE_T:  n.ctl = tcs_pkg::CTL_TORQUE;
      tcs_pkg::MODE_TZ: begin
        n.ctl    = tcs_pkg::CTL_TORQUE;
        n.zero_t = 1'b1;
      end
      tcs_pkg::MODE_PT_S: begin
        n.ctl = q.sync2[tcs_pkg::PIN_SP_SW] ? tcs_pkg::CTL_SPEED :
                tcs_pkg::CTL_PULSE_POS;
      end
      tcs_pkg::MODE_PT_T: begin
        n.ctl = q.sync2[tcs_pkg::PIN_TP_SW] ? tcs_pkg::CTL_TORQUE :
                tcs_pkg::CTL_PULSE_POS;
      end
      tcs_pkg::MODE_S_T: begin
        n.ctl = q.sync2[tcs_pkg::PIN_ST_SW] ? tcs_pkg::CTL_TORQUE :
                tcs_pkg::CTL_SPEED;
      end
      default: n.ctl = tcs_pkg::CTL_TORQUE;
    endcase
    n.pulse_en = (n.ctl == tcs_pkg::CTL_PULSE_POS);

    // Analog path: scale, then low-pass
    vin = analog_ref_mv_in;
    if (vin > tcs_pkg::ANALOG_MAX_MV) begin
      vin = tcs_pkg::ANALOG_MAX_MV;
    end else if (vin < -tcs_pkg::ANALOG_MAX_MV) begin
      vin = -tcs_pkg::ANALOG_MAX_MV;
    end
    prod   = 32'(vin) * $signed({16'h0000, q.full_scale});
    scaled = prod / 32'(tcs_pkg::SCALE_DIV);
    target = 24'(scaled) <<< tcs_pkg::LPF_FRAC;
    if (analog_valid_in) begin
      n.lpf = q.lpf + ((target - q.lpf) >>> LPF_SHIFT);
    end
    analog_pct = 16'(q.lpf >>> tcs_pkg::LPF_FRAC);

    // Torque source select
    tsel = {q.sync2[tcs_pkg::PIN_TSEL1],
            q.sync2[tcs_pkg::PIN_TSEL0]};
    case (tsel)
      2'h0: tsel_val = n.zero_t ? '0 : analog_pct;
      2'h1: tsel_val = 16'(q.tpre1 * tcs_pkg::TENTHS_PER_PCT);
      2'h2: tsel_val = 16'(q.tpre2 * tcs_pkg::TENTHS_PER_PCT);
      default: tsel_val = 16'(q.tpre3 * tcs_pkg::TENTHS_PER_PCT);
    endcase
    if (n.ctl == tcs_pkg::CTL_TORQUE) begin
      n.torque_cmd = tsel_val;
      n.torque_lim = '0;
      n.lim_active = 1'b0;
    end else begin
      n.torque_cmd = '0;
      n.torque_lim = tsel_val;
      n.lim_active = 1'b1;
    end

    // Speed source select
    ssel = {q.sync2[tcs_pkg::PIN_SSEL1], q.sync2[tcs_pkg::PIN_SSEL0]};
    case (ssel)
      2'h0: n.speed_cmd = zero_s ? '0 : vin;
      2'h1: n.speed_cmd = q.spre1;
      2'h2: n.speed_cmd = q.spre2;
      default: n.speed_cmd = q.spre3;
    endcase
    if (n.ctl != tcs_pkg::CTL_SPEED) begin
      n.speed_cmd = '0;
    end

    // Read port
    n.rdata = '0;
    if (rd_in) begin
      case (addr_in)
        tcs_pkg::ADDR_FULL_SCALE: n.rdata = q.full_scale;
        tcs_pkg::ADDR_MODE:       n.rdata = {8'h00, q.mode};
        tcs_pkg::ADDR_TPRE1:      n.rdata = q.tpre1;
        tcs_pkg::ADDR_TPRE2:      n.rdata = q.tpre2;
        tcs_pkg::ADDR_TPRE3:      n.rdata = q.tpre3;
        tcs_pkg::ADDR_SPRE1:      n.rdata = q.spre1;
        tcs_pkg::ADDR_SPRE2:      n.rdata = q.spre2;
        tcs_pkg::ADDR_SPRE3:      n.rdata = q.spre3;
        tcs_pkg::ADDR_TORQUE_RD:  n.rdata = q.torque_cmd;
        tcs_pkg::ADDR_LIMIT_RD:   n.rdata = q.torque_lim;
        tcs_pkg::ADDR_STATUS: begin
          n.rdata[tcs_pkg::ST_CTL_LSB +: 2]  = q.ctl;
          n.rdata[tcs_pkg::ST_ZERO_T]        = q.zero_t;
          n.rdata[tcs_pkg::ST_PULSE]         = q.pulse_en;
          n.rdata[tcs_pkg::ST_LIMIT]         = q.lim_active;
          n.rdata[tcs_pkg::ST_TSEL_LSB +: 2] = tsel;
        end
        default: n.rdata = '0;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= RST_STATE;
    end else if (ce_in) begin
      q <= n;
    end
  end

  assign rd_data_out               = q.rdata;
  assign torque_cmd_out            = q.torque_cmd;
  assign torque_limit_out          = q.torque_lim;
  assign torque_limit_active_out   = q.lim_active;
  assign speed_cmd_out             = q.speed_cmd;
  assign control_path_out          = q.ctl;
  assign pulse_position_enable_out = q.pulse_en;
  assign di_map_out                = q.di_map;

endmodule

/* File: sim/tcs_ctrl_model.sv */
// Motion controller model driving the select pins and analog reference
`timescale 1ns/1ps
module tcs_ctrl_model (
  input  wire logic               sys_clk_in,
  input  wire logic [1:0]         tsel_req_in,
  input  wire logic [1:0]         ssel_req_in,
  input  wire logic [2:0]         sw_req_in,
  input  wire logic signed [15:0] mv_req_in,
  output logic [1:0]              tsel_out,
  output logic [1:0]              ssel_out,
  output logic [2:0]              sw_out,
  output logic signed [15:0]      mv_out,
  output logic                    valid_out
);
  // Pins change only after an edge and then hold
  initial begin
    tsel_out  = 2'h0;
    ssel_out  = 2'h0;
    sw_out    = 3'h0;
    mv_out    = 16'sh0000;
    valid_out = 1'b0;
    forever begin
      @(posedge sys_clk_in);
      tsel_out  <= tsel_req_in;
      ssel_out  <= ssel_req_in;
      sw_out    <= sw_req_in;
      mv_out    <= mv_req_in;
      valid_out <= 1'b1;
    end
  end
endmodule

/* File: sim/tcs_chk.sv */
// Port-level assertions of the torque command select block
`timescale 1ns/1ps
module tcs_chk #(
  parameter int LPF_SHIFT = 4
) (
  input wire logic               sys_clk_in,
  input wire logic               arst_n_in,
  input wire logic               ce_in,
  input wire logic [15:0]        addr_in,
  input wire logic [15:0]        wr_data_in,
  input wire logic               wr_in,
  input wire logic               rd_in,
  input wire logic [15:0]        rd_data_out,
  input wire logic signed [15:0] torque_cmd_out,
  input wire logic signed [15:0] torque_limit_out,
  input wire logic               torque_limit_active_out,
  input wire logic signed [15:0] speed_cmd_out,
  input wire logic [1:0]         control_path_out,
  input wire logic               pulse_position_enable_out,
  input wire logic [7:0]         di_map_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  chk_rd_idle: assert property ($past(ce_in) && !$past(rd_in) |->
    rd_data_out == 16'h0000) else $error("read data outside slot");
  chk_limit_flag: assert property (torque_limit_active_out ==
    (control_path_out != 2'd3)) else $error("limit flag wrong");
  chk_torque_gate: assert property (control_path_out != 2'd3 |->
    torque_cmd_out == 16'sh0000) else $error("torque outside path");
  chk_limit_gate: assert property (control_path_out == 2'd3 |->
    torque_limit_out == 16'sh0000) else $error("limit in torque path");
  chk_pulse_path: assert property (pulse_position_enable_out ==
    (control_path_out == 2'd0)) else $error("pulse enable wrong");
  chk_speed_gate: assert property (control_path_out != 2'd2 |->
    speed_cmd_out == 16'sh0000) else $error("speed outside path");
  chk_cmd_range: assert property (torque_cmd_out >= -16'sd10000 &&
    torque_cmd_out <= 16'sd10000) else $error("torque out of range");
  chk_mode_apply: assert property (wr_in && ce_in &&
    addr_in == 16'h0102 &&
    wr_data_in inside {16'h0006, 16'h0007, 16'h000a} |->
    ##1 di_map_out == $past(wr_data_in[7:0]))
    else $error("mode write not applied");
  chk_mode_legal: assert property (di_map_out inside
    {[8'h00:8'h07], 8'h0a}) else $error("illegal mode code");
  cov_speed: cover property (control_path_out == 2'd2);
  cov_read: cover property (rd_in ##1 rd_data_out != 16'h0000);
  cov_pulse: cover property ($rose(pulse_position_enable_out));
endmodule
bind tcs_top tcs_chk #(.LPF_SHIFT(LPF_SHIFT)) chk_u (
  .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
  .rd_in(rd_in), .rd_data_out(rd_data_out),
  .torque_cmd_out(torque_cmd_out), .torque_limit_out(torque_limit_out),
  .torque_limit_active_out(torque_limit_active_out),
  .speed_cmd_out(speed_cmd_out), .control_path_out(control_path_out),
  .pulse_position_enable_out(pulse_position_enable_out),
  .di_map_out(di_map_out));

/* File: sim/testbench.sv */
// Register and pin level testbench of the torque command select block
`timescale 1ns/1ps
module testbench;
  logic clk, arst_n, ce, wr, rd, vld;
  logic [15:0] addr, wdat, rdat;
  logic [1:0] tsel, ssel, p_tsel, p_ssel, path;
  logic [2:0] sw, p_sw;
  logic signed [15:0] mv, p_mv, tq, lim, spd, e;
  logic lim_act, pen;
  logic [7:0] dmap;
  int n_fail, n_checks, i;
  logic [15:0] tbl [6] = '{16'h0600, 16'h0612, 16'h0700, 16'h0723,
                           16'h0a43, 16'h0a02};
  tcs_ctrl_model ctl_u (.sys_clk_in(clk), .tsel_req_in(tsel),
    .ssel_req_in(ssel), .sw_req_in(sw), .mv_req_in(mv),
    .tsel_out(p_tsel), .ssel_out(p_ssel), .sw_out(p_sw),
    .mv_out(p_mv), .valid_out(vld));
  tcs_top #(.LPF_SHIFT(1)) dut_u (.sys_clk_in(clk), .arst_n_in(arst_n),
    .ce_in(ce), .addr_in(addr), .wr_data_in(wdat), .wr_in(wr),
    .rd_in(rd), .torque_select_bit0_in(p_tsel[0]),
    .torque_select_bit1_in(p_tsel[1]), .speed_select_bit0_in(p_ssel[0]),
    .speed_select_bit1_in(p_ssel[1]), .speed_position_switch_in(p_sw[0]),
    .torque_position_switch_in(p_sw[1]),
    .speed_torque_switch_in(p_sw[2]), .analog_ref_mv_in(p_mv),
    .analog_valid_in(vld), .rd_data_out(rdat), .torque_cmd_out(tq),
    .torque_limit_out(lim), .torque_limit_active_out(lim_act),
    .speed_cmd_out(spd), .control_path_out(path),
    .pulse_position_enable_out(pen), .di_map_out(dmap));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic near(input logic signed [15:0] v,
                      input logic signed [15:0] x);
    chk({15'h0000, (v >= x - 16'sd1 && v <= x + 16'sd1)}, 16'h0001);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wrt(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdat <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, exp);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    n_fail++;
    test_done;
  end
  initial begin
    arst_n = 1'b0; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 16'h0000;
    wdat = 16'h0000; tsel = 2'h0; ssel = 2'h0; sw = 3'h0; mv = 16'sh0;
    n_fail = 0; n_checks = 0;
    wt(12);
    arst_n <= 1'b1;
    rdc(tcs_pkg::ADDR_FULL_SCALE, 16'h0064);
    chk({8'h00, dmap}, 16'h0003);
    $display("reset values done");
    wrt(tcs_pkg::ADDR_TPRE1, 16'h0064);
    wrt(tcs_pkg::ADDR_TPRE2, 16'hffce);
    wrt(tcs_pkg::ADDR_TPRE3, 16'h0190);
    rdc(tcs_pkg::ADDR_TPRE3, 16'h012c);
    for (i = 1; i < 4; i++) begin
      tsel <= i[1:0];
      wt(6);
      e = (i == 1) ? 16'sd1000 : (i == 2) ? -16'sd500 : 16'sd3000;
      chk(tq, e);
    end
    rdc(tcs_pkg::ADDR_TORQUE_RD, 16'h0bb8);
    $display("torque presets done");
    wrt(tcs_pkg::ADDR_FULL_SCALE, 16'h07d0);
    rdc(tcs_pkg::ADDR_FULL_SCALE, 16'h03e8);
    wrt(tcs_pkg::ADDR_FULL_SCALE, 16'h00c8);
    tsel <= 2'h0;
    for (i = 0; i < 2; i++) begin
      mv <= i[0] ? -16'sd5000 : 16'sd5000;
      wt(40);
      near(tq, i[0] ? -16'sd1000 : 16'sd1000);
    end
    $display("analog path done");
    wrt(tcs_pkg::ADDR_MODE, 16'h0005);
    wt(6);
    chk(tq, 16'h0000);
    tsel <= 2'h1;
    wt(6);
    chk(tq, 16'sd1000);
    $display("zero torque done");
    wrt(tcs_pkg::ADDR_SPRE1, 16'h007b);
    wrt(tcs_pkg::ADDR_MODE, 16'h0002);
    ssel <= 2'h1;
    wt(6);
    chk({15'h0000, lim_act}, 16'h0001);
    chk(lim, 16'sd1000);
    chk(spd, 16'h007b);
    tsel <= 2'h0;
    wt(40);
    near(lim, -16'sd1000);
    $display("speed limit done");
    for (i = 0; i < 6; i++) begin
      wrt(tcs_pkg::ADDR_MODE, {8'h00, tbl[i][15:8]});
      sw <= tbl[i][6:4];
      wt(6);
      chk({14'h0000, path}, {14'h0000, tbl[i][1:0]});
      chk({15'h0000, pen}, {15'h0000, tbl[i][1:0] == 2'd0});
    end
    $display("dual modes done");
    wrt(tcs_pkg::ADDR_MODE, 16'h0008);
    wrt(tcs_pkg::ADDR_MODE, 16'h0106);
    wt(3);
    chk({8'h00, dmap}, 16'h000a);
    rdc(16'h0300, 16'h0000);
    $display("refusals done");
    wrt(tcs_pkg::ADDR_MODE, 16'h0004);
    ssel <= 2'h0;
    wt(6);
    chk({14'h0000, path}, 16'h0002);
    chk(spd, 16'h0000);
    wrt(tcs_pkg::ADDR_MODE, 16'h0001);
    wt(6);
    chk({14'h0000, path}, 16'h0001);
    near(lim, -16'sd1000);
    wrt(tcs_pkg::ADDR_MODE, 16'h0000);
    wt(6);
    near(lim, -16'sd1000);
    rdc(tcs_pkg::ADDR_STATUS, 16'h0018);
    tsel <= 2'h1;
    wt(6);
    chk(lim, 16'sd1000);
    ce <= 1'b0;
    tsel <= 2'h2;
    wt(8);
    chk(lim, 16'sd1000);
    ce <= 1'b1;
    wt(6);
    chk(lim, -16'sd500);
    $display("single modes and enable done");
    arst_n <= 1'b0;
    wt(2);
    arst_n <= 1'b1;
    rdc(tcs_pkg::ADDR_MODE, 16'h0003);
    rdc(tcs_pkg::ADDR_FULL_SCALE, 16'h0064);
    wt(4);
    chk(tq, 16'h0000);
    $display("mid-run reset done");
    test_done;
  end
endmodule
